// [rtl/adcsp_defines.vh]
// Purpose: constants for the converter serial port and control block
// Assumes: 40 MHz master clock on clk
// Notes:   offsets are byte addresses on the register bus
`ifndef ADCSP_DEFINES_VH
`define ADCSP_DEFINES_VH
// register bus byte offsets
`define ADCSP_OFF_CTRL      4'h0
`define ADCSP_OFF_GAIN      4'h4
`define ADCSP_OFF_OVRLIM    4'h8
`define ADCSP_OFF_STATUS    4'hC
// serial write register addresses
`define ADCSP_SA_CTRL       16'h0001
`define ADCSP_SA_GAIN       16'h0002
`define ADCSP_SA_OVRLIM     16'h0003
// control register fields
`define ADCSP_CTRL_LOW_POWER_FLAG     0
`define ADCSP_CTRL_RD_STAT  1
`define ADCSP_CTRL_RD_OVR   2
`define ADCSP_CTRL_RD_GAIN  3
// reset values
`define ADCSP_CTRL_RST      4'h0
`define ADCSP_GAIN_RST      16'h8000
`define ADCSP_OVRLIM_RST    16'hCCCC
// frame timing in master clock cycles, write word length in bits
`define ADCSP_LAST_64       9'h07F
`define ADCSP_LAST_128      9'h0FF
`define ADCSP_LAST_256      9'h1FF
`define ADCSP_WORD_BITS     6'h20
// frames of filter settling after reset, sync or write
`define ADCSP_SETTLE_FRAMES 8'h08
// decimation status codes {hi, lo}
`define ADCSP_DEC_64        2'h1
`define ADCSP_DEC_128       2'h2
`define ADCSP_DEC_256       2'h0
`endif

// [rtl/adcsp_top.v]
// Purpose: serial result port, serial register writes and control
//          logic of a sigma-delta converter, with a register bus
// Assumes: clk is the master clock; pins are asynchronous to it
// Notes:   registers also reachable over Avalon-MM
//
// Local design decisions: the Avalon-MM register port and the placing of the registers.
`include "adcsp_defines.vh"
`timescale 1ns/1ps
`default_nettype none
module adcsp_top (
  input  wire        clk,               // master clock
  input  wire        nrst,              // sync reset, active low
  input  wire        avs_read,          // bus read request
  input  wire        avs_write,         // bus write request
  input  wire [3:0]  avs_address,       // bus byte address
  input  wire [31:0] avs_writedata,     // bus write data
  output reg  [31:0] avs_readdata,      // bus read data
  output reg         avs_waitrequest,   // bus stall
  input  wire [23:0] conv_data,         // filter result, same clock
  input  wire        stage1_strobe,     // first stage output pulse
  input  wire [15:0] stage1_mag,        // first stage magnitude
  input  wire        frame_sync_in,     // write frame pin, low active
  input  wire        serial_data_in,    // write data pin
  input  wire        sync_request_n,    // filter sync pin
  input  wire        reset_powerdown_n, // power-down pin
  input  wire        decim_pin_high,    // select pin tied high
  input  wire        decim_pin_gnd,     // select pin grounded
  output reg         serial_clock_out,  // half-rate serial clock
  output reg         serial_data_out,   // result data
  output reg         frame_sync_out,    // result frame, low active
  output reg         overrange_alert_pin, // stage overrange alert
  output reg         low_power_mode,    // low power to analog side
  output reg         filter_hold,       // filter sequencer held
  output reg         result_take        // pulse: result latched
);

  // every pin is asynchronous to clk, so each one passes two flops
  // before any logic reads it; only the second flop is ever read
  // the cost is two cycles of latency on every pin event, which the
  // receiver below makes up for by delaying its own clock copy
  // idle levels are loaded on reset, except power-down, which loads its active low, so that no false edge is seen
  // when the bus reset is released
  // pin synchronisers, two flops each
  reg [1:0] fsi_q;     // frame input
  reg [1:0] sdi_q;     // data input
  reg [1:0] syn_q;     // sync request
  reg [1:0] rpd_q;     // power-down
  reg [1:0] dhi_q;     // decimation high
  reg [1:0] dgn_q;     // decimation ground

  always @(posedge clk) begin
    if (!nrst) begin
      fsi_q <= 2'h3;
      sdi_q <= 2'h0;
      syn_q <= 2'h3;
      rpd_q <= 2'h0;
      dhi_q <= 2'h0;
      dgn_q <= 2'h0;
    end else begin
      fsi_q <= {fsi_q[0], frame_sync_in};
      sdi_q <= {sdi_q[0], serial_data_in};
      syn_q <= {syn_q[0], sync_request_n};
      rpd_q <= {rpd_q[0], reset_powerdown_n};
      dhi_q <= {dhi_q[0], decim_pin_high};
      dgn_q <= {dgn_q[0], decim_pin_gnd};
    end
  end

  // internal reset covers the bus reset and the power-down pin
  wire rst_all = ~nrst | ~rpd_q[1];
  // sync low holds the sequencer, releases on first high sample
  wire hold = rst_all | ~syn_q[1];

  // the select pin has three states; outside logic resolves it into
  // two wires, and the high wire wins if both are ever seen at once
  // a change of the pin takes effect in the frame under way if the
  // new period is longer; a shorter one may stretch one frame
  // decimation from the three-state select pin
  reg [1:0] dec_code;  // {hi, lo} status code
  reg [8:0] last_cyc;  // final cycle of a frame period
  always @* begin
    if (dhi_q[1]) begin
      dec_code = `ADCSP_DEC_64;
      last_cyc = `ADCSP_LAST_64;
    end else if (dgn_q[1]) begin
      dec_code = `ADCSP_DEC_256;
      last_cyc = `ADCSP_LAST_256;
    end else begin
      dec_code = `ADCSP_DEC_128;
      last_cyc = `ADCSP_LAST_128;
    end
  end

  // one counter drives the serial clock, the frame and the bit index
  // keeping them in one counter means they can never drift apart
  // the counter is held at zero while sync or reset holds, so all
  // devices sharing the sync pin restart their frames together
  // frame start is the cycle in which the counter wraps to zero
  // frame sequencer; frame period is decimation serial clocks
  reg  [8:0] seq_q;  // cycle within frame
  wire [8:0] seq_d = (seq_q == last_cyc) ? 9'h000 : seq_q + 9'h001;
  wire       frm_start = ~hold & (seq_d == 9'h000);

  // registers
  reg [3:0]  ctrl_q;     // control bits
  reg [15:0] gain_q;     // gain correction
  reg [15:0] ovrlim_q;   // overrange limit
  reg        fvalid_q;   // filter settled
  reg [7:0]  settle_q;   // frames since restart
  reg        ovr_acc_q;  // overrange seen this result
  reg        ovr_q;      // overrange flag of last result
  reg [31:0] word_q;     // word being shifted

  wire [4:0] status = {fvalid_q & ~overrange_alert_pin, ovr_q,
                       ctrl_q[`ADCSP_CTRL_LOW_POWER_FLAG], dec_code};

  // serial write receiver state
  reg        fall_p1_q;  // serial clock, delayed once
  reg        fall_p2_q;  // serial clock, delayed twice
  reg        fall_p3_q;  // serial clock, delayed three times
  reg        fsi_last_q; // frame input at previous fall
  reg        rx_act_q;   // receiving a write
  reg [5:0]  rx_cnt_q;   // bits received
  reg [31:0] rx_sh_q;    // received bits
  reg        rx_done_q;  // one-cycle write commit

  // the delayed copies match the pin synchroniser latency, so the
  // fall event lines up with what the host saw at its own pin
  wire fall_evt = fall_p3_q & ~fall_p2_q;

  always @(posedge clk) begin
    if (hold) begin
      fall_p1_q <= 1'b0;
      fall_p2_q <= 1'b0;
      fall_p3_q <= 1'b0;
    end else begin
      fall_p1_q <= serial_clock_out;
      fall_p2_q <= fall_p1_q;
      fall_p3_q <= fall_p2_q;
    end
  end

  // writes are taken on our own serial clock falls, seen late by the
  // same number of cycles as the synchronised data and frame pins
  // a frame input that falls while a write is in progress is not a
  // new write; only a fall seen while idle arms the receiver
  // the commit pulse lasts one cycle and feeds the register file
  // receiver: falling edge of frame input starts a 32 bit write
  always @(posedge clk) begin
    if (rst_all) begin
      fsi_last_q <= 1'b1;
      rx_act_q   <= 1'b0;
      rx_cnt_q   <= 6'h00;
      rx_sh_q    <= 32'h00000000;
      rx_done_q  <= 1'b0;
    end else begin
      rx_done_q <= 1'b0;
      if (fall_evt) begin
        fsi_last_q <= fsi_q[1];
        if (rx_act_q) begin
          // each fall during a write shifts in one data bit
          rx_sh_q  <= {rx_sh_q[30:0], sdi_q[1]};
          rx_cnt_q <= rx_cnt_q + 6'h01;
          if (rx_cnt_q == `ADCSP_WORD_BITS - 6'h01) begin
            rx_act_q  <= 1'b0;
            rx_done_q <= 1'b1;
          end
        end else if (fsi_last_q & ~fsi_q[1]) begin
          rx_act_q <= 1'b1;
          rx_cnt_q <= 6'h00;
        end
      end
    end
  end

  // waitrequest is high at idle and drops for exactly one cycle per
  // access; the write lands and read data stand at that edge
  // the fixed latency keeps the slave simple, at the cost of one
  // stalled cycle on every access
  // a serial write and a bus write in one cycle: the serial one wins
  // register bus: one wait cycle, then the access completes
  wire bus_req = avs_read | avs_write;
  wire bus_go  = bus_req & ~avs_waitrequest;
  wire bus_wr  = avs_write & bus_go;
  wire [15:0] rx_addr = rx_sh_q[31:16];
  wire [15:0] rx_data = rx_sh_q[15:0];
  // a serial write beats a bus write in the same cycle
  wire wr_ctrl = rx_done_q ? (rx_addr == `ADCSP_SA_CTRL) :
                 bus_wr & (avs_address == `ADCSP_OFF_CTRL);
  wire wr_gain = rx_done_q ? (rx_addr == `ADCSP_SA_GAIN) :
                 bus_wr & (avs_address == `ADCSP_OFF_GAIN);
  wire wr_olim = rx_done_q ? (rx_addr == `ADCSP_SA_OVRLIM) :
                 bus_wr & (avs_address == `ADCSP_OFF_OVRLIM);
  wire [15:0] wdat = rx_done_q ? rx_data : avs_writedata[15:0];
  wire any_wr = wr_ctrl | wr_gain | wr_olim;
  wire rb_sel = |ctrl_q[3:1];

  always @(posedge clk) begin
    if (rst_all) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h00000000;
    end else if (bus_go) begin
      avs_waitrequest <= 1'b1;
    end else if (bus_req) begin
      avs_waitrequest <= 1'b0;
      case (avs_address)
        `ADCSP_OFF_CTRL:   avs_readdata <= {28'h0000000, ctrl_q};
        `ADCSP_OFF_GAIN:   avs_readdata <= {16'h0000, gain_q};
        `ADCSP_OFF_OVRLIM: avs_readdata <= {16'h0000, ovrlim_q};
        `ADCSP_OFF_STATUS: avs_readdata <= {27'h0000000, status};
        default:           avs_readdata <= 32'h00000000;
      endcase
    end
  end

  // registers keep their values through a sync; only the bus reset
  // or the power-down pin returns them to their reset values
  // the readback select bits clear themselves at the frame start
  // that sends the selected register, so results resume afterwards
  // register file
  always @(posedge clk) begin
    if (rst_all) begin
      ctrl_q   <= `ADCSP_CTRL_RST;
      gain_q   <= `ADCSP_GAIN_RST;
      ovrlim_q <= `ADCSP_OVRLIM_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= wdat[3:0];
      end else if (frm_start & rb_sel) begin
        // select lasts one frame; a new write above wins
        ctrl_q <= ctrl_q & 4'h1;
      end
      if (wr_gain) begin
        gain_q <= wdat;
      end
      if (wr_olim) begin
        ovrlim_q <= wdat;
      end
    end
  end

  // settling is counted in whole frames, not in clock cycles, so the
  // wait scales with the decimation setting on its own
  // any register write restarts it, because a new gain or limit
  // changes the results that follow
  // settling: restarted by reset, sync or any write
  always @(posedge clk) begin
    if (hold | any_wr) begin
      settle_q <= 8'h00;
      fvalid_q <= 1'b0;
    end else if (frm_start) begin
      if (settle_q == `ADCSP_SETTLE_FRAMES) begin
        fvalid_q <= 1'b1;
      end else begin
        settle_q <= settle_q + 8'h01;
      end
    end
  end

  // the pin follows every first stage sample, while the flag gathers
  // all samples of one result and is sampled at the frame start
  // a sample that exceeds the limit in the frame start cycle itself
  // still counts for the result being closed
  // overrange: pin tracks each first stage sample
  wire over_now = stage1_strobe & (stage1_mag > ovrlim_q);
  always @(posedge clk) begin
    if (rst_all) begin
      overrange_alert_pin <= 1'b0;
      ovr_acc_q           <= 1'b0;
      ovr_q               <= 1'b0;
    end else begin
      if (stage1_strobe) begin
        overrange_alert_pin <= over_now;
      end
      if (frm_start) begin
        // flag set from any sample of that result
        ovr_q     <= ovr_acc_q | over_now;
        ovr_acc_q <= 1'b0;
      end else if (over_now) begin
        ovr_acc_q <= 1'b1;
      end
    end
  end

  // readback word chosen at frame start; status has priority
  reg [15:0] rb_val;
  always @* begin
    if (ctrl_q[`ADCSP_CTRL_RD_STAT]) begin
      rb_val = {11'h000, status};
    end else if (ctrl_q[`ADCSP_CTRL_RD_OVR]) begin
      rb_val = ovrlim_q;
    end else begin
      rb_val = gain_q;
    end
  end

  // bits are launched on the rising serial clock and stand for a
  // whole serial period, so the host can take them on the fall
  // the word is latched at frame start; conv_data must be valid then
  // the first frame after a release carries an empty word, because
  // nothing has been latched yet at that point
  // serial output: clock, frame and data from one sequencer
  always @(posedge clk) begin
    if (hold) begin
      seq_q            <= 9'h000;
      serial_clock_out <= 1'b0;
      frame_sync_out   <= 1'b1;
      serial_data_out  <= 1'b0;
      word_q           <= 32'h00000000;
      result_take      <= 1'b0;
    end else begin
      seq_q            <= seq_d;
      serial_clock_out <= seq_d[0];
      result_take      <= frm_start;
      if (frm_start) begin
        if (rb_sel) begin
          word_q <= {rb_val, 16'h0000};
        end else begin
          word_q <= {conv_data, status, 3'h0};
        end
      end
      if (seq_d[0]) begin
        // rising serial clock: launch the next bit
        if (seq_d[8:6] == 3'h0) begin
          frame_sync_out  <= 1'b0;
          serial_data_out <= word_q[~seq_d[5:1]];
        end else begin
          frame_sync_out  <= 1'b1;
          serial_data_out <= 1'b0;
        end
      end
    end
  end

  // power and filter controls to the analog and filter sections
  always @(posedge clk) begin
    if (rst_all) begin
      low_power_mode <= 1'b0;
      filter_hold    <= 1'b1;
    end else begin
      low_power_mode <= ctrl_q[`ADCSP_CTRL_LOW_POWER_FLAG];
      filter_hold    <= hold;
    end
  end

endmodule
`default_nettype wire

// [test/adcsp_properties.sv]
// Purpose: port assertions for the converter serial port block
// Assumes: one clk domain, nrst synchronous and active low
// Notes:   lcnt_q counts clk cycles of the current low frame
`include "adcsp_defines.vh"
`timescale 1ns/1ps
`default_nettype none
module adcsp_props (
  input wire logic        clk,              // master clock
  input wire logic        nrst,             // reset, active low
  input wire logic        avs_read,         // bus read
  input wire logic        avs_write,        // bus write
  input wire logic [3:0]  avs_address,      // bus address
  input wire logic [31:0] avs_writedata,    // bus write data
  input wire logic        avs_waitrequest,  // bus stall
  input wire logic        sync_request_n,   // sync pin
  input wire logic        serial_clock_out, // serial clock
  input wire logic        serial_data_out,  // serial data
  input wire logic        frame_sync_out,   // frame, low
  input wire logic        low_power_mode,   // low power
  input wire logic        filter_hold       // sequencer held
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  logic [6:0] lcnt_q; // low cycles so far in this frame
  // cleared while high, so the frame length shows in the cycle fso rises
  always_ff @(posedge clk) lcnt_q <= (!nrst || frame_sync_out) ? 7'h00 : lcnt_q + 7'h01;
  sequence s_sync_low; !sync_request_n [*4]; endsequence
  sequence s_req; (avs_read || avs_write) && avs_waitrequest; endsequence
  property p_half; !filter_hold && !$past(filter_hold) |-> serial_clock_out != $past(serial_clock_out); endproperty
  a_half: assert property (p_half) else $error("serial clock not half rate");
  // a hold may cut a frame short, so only undisturbed frames are measured
  property p_len; $rose(frame_sync_out) && !filter_hold && !$past(filter_hold) |-> lcnt_q == 7'h40; endproperty
  a_len: assert property (p_len) else $error("frame not 32 serial clocks");
  property p_tail; !frame_sync_out && lcnt_q > 7'h39 |-> !serial_data_out; endproperty
  a_tail: assert property (p_tail) else $error("last three bits not zero");
  property p_launch; $changed(serial_data_out) && !filter_hold |-> $rose(serial_clock_out); endproperty
  a_launch: assert property (p_launch) else $error("data changed off rising serial clock");
  property p_one; !avs_waitrequest |=> avs_waitrequest; endproperty
  a_one: assert property (p_one) else $error("waitrequest low too long");
  property p_ack; s_req |=> !avs_waitrequest; endproperty
  a_ack: assert property (p_ack) else $error("bus request not answered");
  property p_lowpow; avs_write && !avs_waitrequest && avs_address == `ADCSP_OFF_CTRL
    |=> ##1 low_power_mode == $past(avs_writedata[0], 2); endproperty
  a_lowpow: assert property (p_lowpow) else $error("low power bit not applied");
  property p_sync; s_sync_low |=> filter_hold; endproperty
  a_sync: assert property (p_sync) else $error("sync did not hold sequencer");
  property p_idle; filter_hold && $past(filter_hold) |-> frame_sync_out; endproperty
  a_idle: assert property (p_idle) else $error("frame during hold");
  property p_align; $fell(filter_hold) |-> ##[0:4] $fell(frame_sync_out); endproperty
  a_align: assert property (p_align) else $error("frame not aligned to release");
endmodule
bind adcsp_top adcsp_props adcsp_props_i (.clk, .nrst, .avs_read, .avs_write, .avs_address, .avs_writedata,
  .avs_waitrequest, .sync_request_n, .serial_clock_out, .serial_data_out, .frame_sync_out, .low_power_mode,
  .filter_hold);
`default_nettype wire

// [test/adcsp_host.sv]
// Purpose: host controller model on the serial pins
// Assumes: device serial clock is free running inside frames
// Notes:   write line shows the inverse of its last bit when idle
`timescale 1ns/1ps
`default_nettype none
module adcsp_host (
  input  wire logic        serial_clock_out, // device serial clock
  input  wire logic        serial_data_out,  // device result data
  input  wire logic        frame_sync_out,   // device frame, low
  output var  logic        frame_sync_in,    // write frame, low
  output var  logic        serial_data_in,   // write data
  output var  logic [31:0] word_q,           // last word taken
  output var  logic [15:0] nwords_q          // words taken
);
  logic [31:0] sh_q; // shift of the word in progress
  logic [5:0]  n_q;  // bits taken in this frame
  initial begin
    frame_sync_in = 1'b1;
    serial_data_in = 1'b0;
    nwords_q = 16'h0000;
    n_q = 6'h00;
  end
  // capture on the falling serial clock, half a period after launch
  always @(negedge serial_clock_out) begin
    if (!frame_sync_out) begin
      sh_q = {sh_q[30:0], serial_data_out};
      n_q = n_q + 6'h01;
      if (n_q == 6'h20) begin
        word_q <= sh_q;
        nwords_q <= nwords_q + 16'h0001;
        n_q = 6'h00;
      end
    end else begin
      n_q = 6'h00; // a cut frame must not skew the next word
    end
  end
  // frame low one period, then address and data msb first after each rise
  task automatic send(input logic [31:0] d);
    integer i;
    @(posedge serial_clock_out) frame_sync_in <= 1'b0;
    for (i = 31; i >= 0; i--) begin
      @(posedge serial_clock_out) frame_sync_in <= 1'b1;
      serial_data_in <= d[i];
    end
    @(posedge serial_clock_out) serial_data_in <= ~d[0];
  endtask
endmodule
`default_nettype wire

// [test/adcsp_bench.sv]
// Purpose: self-checking bench for the converter serial port block
// Assumes: 40 MHz clk, host model on the serial pins
// Notes:   expected words are built from pin and register settings
`include "adcsp_defines.vh"
`timescale 1ns/1ps
`default_nettype none
module adcsp_bench;
  logic clk = 1'b0, nrst = 1'b0, avs_read = 1'b0, avs_write = 1'b0, stage1_strobe = 1'b0;
  logic sync_request_n = 1'b1, reset_powerdown_n = 1'b1, decim_pin_high = 1'b1, decim_pin_gnd = 1'b0;
  logic [3:0]  avs_address = 4'h0;
  logic [15:0] stage1_mag = 16'h0000, nwords;
  logic [23:0] conv_data = 24'hA5C3E1; // result pattern
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rv, w, word;
  logic avs_waitrequest, frame_sync_in, serial_data_in, serial_clock_out, serial_data_out;
  logic frame_sync_out, overrange_alert_pin, low_power_mode, filter_hold, result_take;
  logic [1:0]  pin[3] = '{2'h2, 2'h0, 2'h1}, dc[3] = '{`ADCSP_DEC_64, `ADCSP_DEC_128, `ADCSP_DEC_256};
  logic [31:0] mk[3] = '{32'hFFFFFF7F, 32'hFFFFFF77, 32'hFFFFFF7F}; // settle bit and 128x low bit free
  integer mismatches = 0, checked = 0, i, dt, per[3] = '{128, 256, 512};
  adcsp_top adcsp_top_i (.clk, .nrst, .avs_read, .avs_write, .avs_address, .avs_writedata, .avs_readdata,
    .avs_waitrequest, .conv_data, .stage1_strobe, .stage1_mag, .frame_sync_in, .serial_data_in, .sync_request_n,
    .reset_powerdown_n, .decim_pin_high, .decim_pin_gnd, .serial_clock_out, .serial_data_out, .frame_sync_out,
    .overrange_alert_pin, .low_power_mode, .filter_hold, .result_take);
  adcsp_host adcsp_host_i (.serial_clock_out, .serial_data_out, .frame_sync_out, .frame_sync_in, .serial_data_in,
    .word_q(word), .nwords_q(nwords));
  always #12.5 clk = ~clk;
  task automatic chk(input logic [31:0] got, exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // one access: hold until waitrequest is seen low, then release a cycle
  task automatic bus(input logic r, input logic [3:0] a, input logic [31:0] d);
    avs_read <= r;
    avs_write <= !r;
    avs_address <= a;
    avs_writedata <= d;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    rv = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask
  // next whole word from the host, with its distance in clk cycles
  task automatic nxt;
    logic [15:0] n0;
    realtime t0;
    n0 = nwords;
    t0 = $realtime;
    wait (nwords != n0);
    w = word;
    dt = ($realtime - t0) / 25.0;
  endtask
  function automatic logic [31:0] ew(input logic fv, ov, lp, input logic [1:0] d);
    return {conv_data, fv, ov, lp, d, 3'h0};
  endfunction
  task automatic summarize;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    #1000000;
    mismatches++;
    summarize();
  end
  initial begin
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    bus(1, `ADCSP_OFF_CTRL, 0);
    chk(rv, 32'h0);
    bus(1, `ADCSP_OFF_GAIN, 0);
    chk(rv, `ADCSP_GAIN_RST);
    bus(1, 4'h2, 0);
    chk(rv, 32'h0);
    // every pin setting: frame period and decimation code
    for (i = 0; i < 3; i++) begin
      {decim_pin_high, decim_pin_gnd} <= pin[i];
      repeat (3) nxt();
      chk(dt, per[i]);
      chk(w & mk[i], ew(0, 0, 0, dc[i]) & mk[i]);
    end
    repeat (2) nxt();
    chk(w, ew(1, 0, 0, 0));
    stage1_mag <= 16'hFFFF;
    stage1_strobe <= 1'b1;
    @(posedge clk) stage1_strobe <= 1'b0;
    repeat (2) nxt();
    chk(overrange_alert_pin, 1);
    chk(w, ew(0, 1, 0, 0));
    stage1_mag <= 16'h0000;
    stage1_strobe <= 1'b1;
    @(posedge clk) stage1_strobe <= 1'b0;
    repeat (2) nxt();
    chk(overrange_alert_pin, 0);
    chk(w, ew(1, 0, 0, 0));
    adcsp_host_i.send({`ADCSP_SA_CTRL, 16'h0008});
    nxt();
    chk(w, {`ADCSP_GAIN_RST, 16'h0});
    nxt();
    chk(w, ew(0, 0, 0, 0));
    adcsp_host_i.send({`ADCSP_SA_CTRL, 16'h0001});
    repeat (2) nxt();
    chk(w, ew(0, 0, 1, 0));
    bus(0, `ADCSP_OFF_GAIN, 32'h1234);
    bus(1, `ADCSP_OFF_GAIN, 0);
    chk(rv, 32'h1234);
    bus(0, `ADCSP_OFF_CTRL, 32'h0);
    bus(1, `ADCSP_OFF_CTRL, 0);
    chk(rv, 32'h0);
    bus(0, `ADCSP_OFF_CTRL, 32'h1);
    bus(1, `ADCSP_OFF_CTRL, 0);
    chk(rv, 32'h1);
    sync_request_n <= 1'b0;
    repeat (4) @(posedge clk);
    sync_request_n <= 1'b1;
    repeat (2) nxt();
    chk(w, ew(0, 0, 1, 0));
    reset_powerdown_n <= 1'b0;
    repeat (4) @(posedge clk);
    reset_powerdown_n <= 1'b1;
    repeat (4) @(posedge clk);
    chk(low_power_mode, 0);
    bus(1, `ADCSP_OFF_GAIN, 0);
    chk(rv, `ADCSP_GAIN_RST);
    summarize();
  end
endmodule
`default_nettype wire
